/* pep_params.svh */
`ifndef PEP_PARAMS_SVH
`define PEP_PARAMS_SVH
// register word offsets (byte addresses, one aligned word each)
`define PEP_OFS_PIN_VALUES   6'h00
`define PEP_OFS_LATCH        6'h04
`define PEP_OFS_DIRECTION    6'h08
`define PEP_OFS_ANALOG_SEL   6'h0C
`define PEP_OFS_INTCON_TWO   6'h10
`define PEP_OFS_SLEW         6'h14
`define PEP_OFS_CFG3H        6'h18
`define PEP_OFS_CFG4L        6'h1C
`define PEP_OFS_STATUS       6'h20
// field positions
`define PEP_BIT_PULLUP_EN    7
`define PEP_BIT_GPU_DIS_N    7
`define PEP_BIT_MASTER_CLEAR_N_EN      7
`define PEP_BIT_LVP          2
`define PEP_BIT_HV_MODE      0
// writable masks
`define PEP_MASK_LOWER       8'h07
`define PEP_MASK_DIRECTION   8'h87
`define PEP_MASK_INTCON_TWO  8'hF5
`define PEP_MASK_SLEW        8'h1F
`define PEP_MASK_CFG3H       8'hD3
`define PEP_MASK_CFG4L       8'hC5
// reset values
`define PEP_RST_DIRECTION    8'h07
`define PEP_RST_ANALOG_SEL   8'h07
`define PEP_RST_LATCH        8'h00
`define PEP_RST_INTCON_TWO   8'hF5
`define PEP_RST_SLEW         8'h1F
`define PEP_RST_CFG3H        8'h80
`define PEP_RST_CFG4L        8'h38
`define PEP_CFG4L_FIXED      8'h38
`endif

/* pep_pkg.sv */
package pep_pkg;
  // pin-side bundle for the three lower pins
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } pep_drive_t;
  // peripheral request on a lower pin
  typedef struct packed {
    logic [2:0] en;
    logic [2:0] val;
  } pep_periph_t;
  typedef enum logic [1:0] {
    PEP_IDLE = 2'b00,
    PEP_ACK  = 2'b01
  } pep_bus_state_t;
endpackage

/* pep_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser per bit
module pep_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

/* pep_port_e.sv */
`timescale 1ns/10ps
`include "pep_params.svh"
// What this block does
// - four-bit port, three lower pins bidirectional
// - analog-selected lower pins read zero
// - direction 1 input, 0 drives latch
// - direction still gates drivers in analog mode
// - latch register reads back latched values
// - power-on leaves lower pins analog inputs
// - fourth pin input or master clear
// - small package: only fourth pin, no clear
// - direction bit 7 enables fourth pin pull-up
// - global disable gates all enabled pull-ups
// - pull-up enables off after power-on reset; clear forces fourth pin pull-up
// - master clear or low-voltage forces pull-up
// - highest-priority output function owns pin
// - digital outputs drive analog-mode pins too
// - analog disables input, not output path
// - unimplemented bits read zero, except CFG4L bits 5:3 and, in the small package, analog select and unwritten direction bits 2:0, which read one
// - low-voltage bit changes only in high-voltage
// - port write hits latch, read sees pins
// - analog select and direction reset to one
module pep_port_e
  import pep_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  pin_i,
  input  wire logic        hv_program_i,
  input  wire logic        periph_i_en0,
  input  wire pep_periph_t periph_i,
  output logic      [2:0]  pin_o,
  output logic      [2:0]  pin_oe_o,
  output logic      [2:0]  analog_enable_o,
  output logic             pin3_pullup_o,
  output logic             port_b_pullup_allow_o,
  output logic             master_clear_n_o,
  output logic      [4:0]  slew_reduced_o
);
  logic [7:0]  port_e_output_latch;
  logic [7:0]  port_e_direction;
  logic [7:0]  port_e_analog_select;
  logic [7:0]  interrupt_control_two;
  logic [7:0]  port_slew_control;
  logic [7:0]  config_word_three_high;
  logic [7:0]  config_word_four_low;
  logic [3:0]  pin_sync;
  logic [7:0]  port_e_pin_values;
  logic [7:0]  wr_byte;
  logic [7:0]  rd_byte;
  logic        wr_en;
  logic        master_clear_enable;
  logic        low_voltage_program_enable;
  logic        global_pullup_disable_n;
  logic        pin3_pullup_enable;
  logic        port_e_present;
  pep_drive_t  next_drive;
  pep_bus_state_t bus_state;

  // pins run through a synchroniser so a read never sees metastability
  pep_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i  (pin_i),
    .q_o  (pin_sync)
  );

  assign master_clear_enable        = config_word_three_high[`PEP_BIT_MASTER_CLEAR_N_EN];
  assign low_voltage_program_enable = config_word_four_low[`PEP_BIT_LVP];
  assign global_pullup_disable_n    = interrupt_control_two[`PEP_BIT_GPU_DIS_N];
  assign pin3_pullup_enable         = port_e_direction[`PEP_BIT_PULLUP_EN];
  assign wr_byte                    = wb_dat_i[7:0];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && (bus_state == PEP_IDLE);
  // without clear the small package keeps only the fourth pin
  assign port_e_present = LARGE_PACKAGE || !master_clear_enable;

  // classic wishbone: one wait state, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= PEP_IDLE;
      wb_ack_o  <= 1'b0;
    end else begin
      case (bus_state)
        PEP_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_state <= PEP_ACK;
            wb_ack_o  <= 1'b1;
          end
        end
        PEP_ACK: begin
          bus_state <= PEP_IDLE;
          wb_ack_o  <= 1'b0;
        end
        default: begin
          bus_state <= PEP_IDLE;
          wb_ack_o  <= 1'b0;
        end
      endcase
    end
  end

  // latch: written through latch or pin-value offset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_e_output_latch <= `PEP_RST_LATCH;
    end else if (wr_en && LARGE_PACKAGE &&
                 (wb_adr_i == `PEP_OFS_LATCH || wb_adr_i == `PEP_OFS_PIN_VALUES)) begin
      port_e_output_latch <= wr_byte & `PEP_MASK_LOWER;
    end
  end

  // direction and pull-up enable; reset leaves pins as inputs, pull-up off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_e_direction <= `PEP_RST_DIRECTION;
    end else if (wr_en && wb_adr_i == `PEP_OFS_DIRECTION) begin
      port_e_direction <= wr_byte & (LARGE_PACKAGE ? `PEP_MASK_DIRECTION : 8'h80);
    end
  end

  // analog select resets to one so lower pins start analog
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_e_analog_select <= `PEP_RST_ANALOG_SEL;
    end else if (wr_en && LARGE_PACKAGE && wb_adr_i == `PEP_OFS_ANALOG_SEL) begin
      port_e_analog_select <= wr_byte & `PEP_MASK_LOWER;
    end
  end

  // shared control words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_control_two <= `PEP_RST_INTCON_TWO;
      port_slew_control     <= `PEP_RST_SLEW;
    end else if (wr_en) begin
      if (wb_adr_i == `PEP_OFS_INTCON_TWO) begin
        interrupt_control_two <= wr_byte & `PEP_MASK_INTCON_TWO;
      end
      if (wb_adr_i == `PEP_OFS_SLEW) begin
        port_slew_control <= wr_byte & `PEP_MASK_SLEW;
      end
    end
  end

  // config words; low-voltage bit locked unless high-voltage programming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_word_three_high <= `PEP_RST_CFG3H;
      config_word_four_low   <= `PEP_RST_CFG4L;
    end else if (wr_en) begin
      if (wb_adr_i == `PEP_OFS_CFG3H) begin
        config_word_three_high <= wr_byte & `PEP_MASK_CFG3H;
      end
      if (wb_adr_i == `PEP_OFS_CFG4L) begin
        config_word_four_low <= (wr_byte & `PEP_MASK_CFG4L & ~8'h04) | `PEP_CFG4L_FIXED
                              | (hv_program_i ? (wr_byte & 8'h04)
                                              : (config_word_four_low & 8'h04));
      end
    end
  end

  // pin values: analog pins read zero, fourth pin only as port input
  always_comb begin
    port_e_pin_values = 8'h00;
    if (LARGE_PACKAGE) begin
      port_e_pin_values[2:0] = pin_sync[2:0] & ~port_e_analog_select[2:0];
    end
    port_e_pin_values[3] = pin_sync[3] & !master_clear_enable;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (wb_adr_i)
      `PEP_OFS_PIN_VALUES: rd_byte = port_e_present ? port_e_pin_values : 8'h00;
      `PEP_OFS_LATCH:      rd_byte = port_e_output_latch;
      `PEP_OFS_DIRECTION:  rd_byte = port_e_direction;
      `PEP_OFS_ANALOG_SEL: rd_byte = port_e_analog_select;
      `PEP_OFS_INTCON_TWO: rd_byte = interrupt_control_two;
      `PEP_OFS_SLEW:       rd_byte = port_slew_control;
      `PEP_OFS_CFG3H:      rd_byte = config_word_three_high;
      `PEP_OFS_CFG4L:      rd_byte = config_word_four_low;
      `PEP_OFS_STATUS:     rd_byte = {6'h00, port_e_present, pin_sync[3]};
      default:             rd_byte = 8'h00;
    endcase
  end

  // read data registered alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && bus_state == PEP_IDLE) begin
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  // priority: peripheral request first, then latch; direction gates
  // the driver regardless of analog select (software keeps analog pins input)
  always_comb begin
    next_drive.out = 3'h0;
    next_drive.oe  = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (LARGE_PACKAGE) begin
        next_drive.oe[i]  = !port_e_direction[i] || periph_i.en[i];
        next_drive.out[i] = periph_i.en[i] ? periph_i.val[i]
                                           : port_e_output_latch[i];
      end
    end
  end

  // registered pin outputs; analog select never touches the drivers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o           <= 3'h0;
      pin_oe_o        <= 3'h0;
      analog_enable_o <= 3'h0;
    end else begin
      pin_o           <= next_drive.out;
      pin_oe_o        <= next_drive.oe;
      analog_enable_o <= LARGE_PACKAGE ? port_e_analog_select[2:0] : 3'h0;
    end
  end

  // pull-ups and clear; clear or low-voltage mode forces the pull-up on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin3_pullup_o         <= 1'b0;
      port_b_pullup_allow_o <= 1'b0;
      master_clear_n_o      <= 1'b1;
      slew_reduced_o        <= 5'h1F;
    end else begin
      pin3_pullup_o <= master_clear_enable || low_voltage_program_enable
                    || (!global_pullup_disable_n && pin3_pullup_enable);
      port_b_pullup_allow_o <= !global_pullup_disable_n;
      master_clear_n_o      <= !master_clear_enable || pin_sync[3];
      slew_reduced_o        <= port_slew_control[4:0];
    end
  end
endmodule

/* pep_port_e_properties.sv */
`timescale 1ns/10ps
module pep_port_e_properties
  import pep_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire pep_periph_t periph_i,
  input wire logic [2:0]  pin_o,
  input wire logic [2:0]  pin_oe_o,
  input wire logic [2:0]  analog_enable_o,
  input wire logic        pin3_pullup_o,
  input wire logic        master_clear_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request is live while both strobes are up
  wire logic req = wb_cyc_i && wb_stb_i;
  a_ack_after_req: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_data_holds: assert property (!req |=> $stable(wb_dat_o))
    else $error("read data moved while idle");
  a_periph_wins: assert property (periph_i.en == 3'h7 |=>
    pin_oe_o == 3'h7 && pin_o == $past(periph_i.val)) else $error("peripheral lost pin");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i && $past(rst_i) |->
    pin_oe_o == 3'h0 && !pin3_pullup_o && master_clear_n_o) else $error("reset outputs");
  a_analog_start: assert property ($fell(rst_i) |=> analog_enable_o == 3'h7)
    else $error("pins not analog after reset");
endmodule
bind pep_port_e pep_port_e_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .periph_i, .pin_o, .pin_oe_o, .analog_enable_o, .pin3_pullup_o,
  .master_clear_n_o);

/* pep_pins_model.sv */
`timescale 1ns/10ps
// board side of the four pins
module pep_pins_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] drive_i,
  input  wire logic [2:0] oe_i,
  input  wire logic       pullup_i,
  input  wire logic [2:0] ext_val_i,
  input  wire logic [2:0] ext_en_i,
  input  wire logic       ext3_val_i,
  input  wire logic       ext3_en_i,
  output logic      [3:0] pin_o
);
  logic flip = 1'b0;
  // floating lines wander so a stale level never passes as valid
  always @(posedge clk_i) flip <= ~flip;
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      pin_o[k] = oe_i[k] ? drive_i[k] : (ext_en_i[k] ? ext_val_i[k] : flip);
    end
    pin_o[3] = ext3_en_i ? ext3_val_i : (pullup_i ? 1'b1 : flip);
  end
endmodule

/* pep_port_e_tb_top.sv */
`timescale 1ns/10ps
module pep_port_e_tb_top import pep_pkg::*;;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, hv = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] dwr = 32'h0, drd, rd;
  logic [3:0]  sel = 4'h1, pin;
  logic [2:0]  pin_o, oe, ana, ev = 3'h7, een = 3'h7;
  logic        ack, pu, pba, mcn, e3 = 1'b1, e3en = 1'b1;
  logic [4:0]  slew;
  pep_periph_t periph = '0;
  int n_errors = 0, checked = 0;
  logic [5:0] wa [7] = '{6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C};
  logic [7:0] rv [7] = '{8'h00, 8'h07, 8'h07, 8'hF5, 8'h1F, 8'h80, 8'h38};
  logic [7:0] fv [7] = '{8'h07, 8'h87, 8'h07, 8'hF5, 8'h1F, 8'hD3, 8'h00};
  always #20 clk_i = ~clk_i;
  pep_port_e DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
    .pin_i(pin), .hv_program_i(hv), .periph_i_en0(1'b0), .periph_i(periph), .pin_o(pin_o),
    .pin_oe_o(oe), .analog_enable_o(ana), .pin3_pullup_o(pu), .port_b_pullup_allow_o(pba),
    .master_clear_n_o(mcn), .slew_reduced_o(slew));
  pep_pins_model u_pins (.clk_i(clk_i), .drive_i(pin_o), .oe_i(oe), .pullup_i(pu),
    .ext_val_i(ev), .ext_en_i(een), .ext3_val_i(e3), .ext3_en_i(e3en), .pin_o(pin));
  // one classic cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= {24'h0, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t >= 20) n_errors++;
    rd = drd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, rd[7:0]);
  endtask
  task automatic final_report();
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog well beyond the roughly 160 cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++) rc(wa[i], rv[i]);
    chk("pullup", 8'(pu), 8'h01);
    chk("allow", 8'(pba), 8'h00);
    chk("oe", 8'(oe), 8'h00);
    chk("slew", 8'(slew), 8'h1F);
    e3 <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("clear", 8'(mcn), 8'h00);
    rc(6'h00, 8'h00);
    e3 <= 1'b1;
    een <= 3'h5;
    wb(1'b1, 6'h00, 8'h02);
    wb(1'b1, 6'h0C, 8'h00);
    wb(1'b1, 6'h08, 8'h05);
    rc(6'h04, 8'h02);
    chk("oe", 8'(oe), 8'h02);
    chk("drive", 8'(pin_o & oe), 8'h02);
    rc(6'h00, 8'h07);
    wb(1'b1, 6'h0C, 8'h07);
    repeat (3) @(posedge clk_i);
    chk("oe", 8'(oe), 8'h02);
    chk("analog", 8'(ana), 8'h07);
    rc(6'h00, 8'h00);
    rc(6'h04, 8'h02);
    periph <= '{en: 3'h7, val: 3'h5};
    repeat (3) @(posedge clk_i);
    chk("oe", 8'(oe), 8'h07);
    chk("drive", 8'(pin_o), 8'h05);
    periph <= '0;
    for (int i = 0; i < 6; i++) wb(1'b1, wa[i], 8'hFF);
    for (int i = 0; i < 6; i++) rc(wa[i], fv[i]);
    rc(6'h3C, 8'h00);
    hv <= 1'b1;
    wb(1'b1, 6'h1C, 8'h00);
    hv <= 1'b0;
    wb(1'b1, 6'h18, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("pullup", 8'(pu), 8'h00);
    wb(1'b1, 6'h10, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("pullup", 8'(pu), 8'h01);
    chk("allow", 8'(pba), 8'h01);
    wb(1'b1, 6'h08, 8'h07);
    wb(1'b1, 6'h1C, 8'h04);
    rc(6'h1C, 8'h38);
    chk("pullup", 8'(pu), 8'h00);
    hv <= 1'b1;
    wb(1'b1, 6'h1C, 8'h04);
    rc(6'h1C, 8'h3C);
    chk("pullup", 8'(pu), 8'h01);
    rc(6'h00, 8'h08);
    e3 <= 1'b0;
    repeat (4) @(posedge clk_i);
    rc(6'h00, 8'h00);
    chk("clear", 8'(mcn), 8'h01);
    wb(1'b1, 6'h14, 8'h0A);
    repeat (2) @(posedge clk_i);
    chk("slew", 8'(slew), 8'h0A);
    final_report();
  end
endmodule
